// ==== hdl/bbc_pkg.sv ====
/*
 * Shared constants of the backlight brightness control block.
 * Assumes 8-bit registers reached over a two-wire serial bus.
 */
package bbc_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_PER_S = 1_000;
  localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
  localparam int unsigned SAMPLE_DIV = 25;
  localparam int unsigned WIN_LOG2 = 11;
  localparam int unsigned RAMP_STEPS_LOG2 = 8;

  localparam logic [7:0] OFF_CTRL = 8'h02;
  localparam logic [7:0] OFF_RAMP = 8'h03;
  localparam logic [7:0] OFF_BRT_LO = 8'h04;
  localparam logic [7:0] OFF_BRT_HI = 8'h05;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_FBK = 8'h10;

  localparam int unsigned CTRL_PWM_EN = 0;
  localparam int unsigned CTRL_PWM_RAMP = 1;
  localparam int unsigned CTRL_LINEAR = 3;
  localparam int unsigned RAMP_LSB = 3;
  localparam int unsigned ENA_BL = 4;
  localparam int unsigned FBK_LSB = 3;

  localparam logic [7:0] RST_CTRL = 8'h08;
  localparam logic [7:0] RST_RAMP = 8'h00;
  localparam logic [7:0] RST_BRT_LO = 8'h07;
  localparam logic [7:0] RST_BRT_HI = 8'hFF;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_FBK = 8'h00;
  localparam logic [1:0] FBK_BOOST_OFF = 2'h3;

  typedef enum logic [1:0] {
    BBC_SHUTDOWN = 2'b00,
    BBC_STANDBY  = 2'b01,
    BBC_ACTIVE   = 2'b10
  } bbc_state_t;

  typedef enum logic [2:0] {
    BBC_I_IDLE = 3'b000,
    BBC_I_DEVA = 3'b001,
    BBC_I_REGA = 3'b010,
    BBC_I_WDAT = 3'b011,
    BBC_I_RDAT = 3'b100
  } bbc_i2c_t;

  // Ramp duration per setting, milliseconds
  function automatic int unsigned ramp_ms(input logic [3:0] sel);
    int unsigned tbl [16] = '{0, 1, 2, 4, 8, 16, 32, 64, 128, 250, 500,
                              1000, 2000, 4000, 6000, 8000};
    return tbl[sel];
  endfunction
endpackage

// ==== hdl/bbc_i2c_slave.sv ====
/*
 * Two-wire serial register slave: device address, register pointer,
 * then data bytes with auto increment; reads after a repeated start.
 * Assumes pins are synchronised here and rd_data follows addr at once.
 */
`timescale 1ns/10ps
module bbc_i2c_slave import bbc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       en,
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  input  wire logic [7:0] rd_data,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic      [7:0] addr,
  output logic      [7:0] wr_data
);
  logic [2:0] scl_s, sda_s;
  bbc_i2c_t   st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh, nxt_addr, nxt_wd;
  logic       nxt_oe, nxt_stb;
  logic       start, stop, rise, fall;

  assign start = scl_s[1] & sda_s[2] & ~sda_s[1];
  assign stop  = scl_s[1] & ~sda_s[2] & sda_s[1];
  assign rise  = scl_s[1] & ~scl_s[2];
  assign fall  = ~scl_s[1] & scl_s[2];

  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh  = sh_ff;
    nxt_addr = addr;
    nxt_wd  = wr_data;
    nxt_oe  = sda_oe;
    nxt_stb = 1'b0;
    if (!en) begin
      nxt_st  = BBC_I_IDLE;
      nxt_oe  = 1'b0;
      nxt_cnt = 4'h0;
    end else if (start) begin
      nxt_st  = BBC_I_DEVA;
      // The START's own clock fall wraps this to zero before the first bit
      nxt_cnt = 4'hF;
      nxt_oe  = 1'b0;
    end else if (stop) begin
      nxt_st = BBC_I_IDLE;
      nxt_oe = 1'b0;
    end else if (rise && st_ff != BBC_I_IDLE) begin
      if (cnt_ff != 4'h8 && st_ff != BBC_I_RDAT) begin
        nxt_sh = {sh_ff[6:0], sda_s[1]};
      end else if (cnt_ff == 4'h8 && st_ff == BBC_I_RDAT && sda_s[1]) begin
        nxt_st = BBC_I_IDLE;  // Master refused, stop sending
      end
    end else if (fall && st_ff != BBC_I_IDLE) begin
      if (cnt_ff == 4'h7) begin
        nxt_cnt = 4'h8;
        nxt_oe  = 1'b1;
        unique case (st_ff)
          BBC_I_DEVA: begin
            if (sh_ff[7:1] != DEV_ADDR) begin
              nxt_st = BBC_I_IDLE;
              nxt_oe = 1'b0;
            end
          end
          BBC_I_REGA: nxt_addr = sh_ff;
          BBC_I_WDAT: begin
            nxt_stb = 1'b1;
            nxt_wd  = sh_ff;
          end
          BBC_I_RDAT: begin
            nxt_oe   = 1'b0;
            nxt_addr = addr + 8'h01;
          end
          default: nxt_st = BBC_I_IDLE;
        endcase
      end else if (cnt_ff == 4'h8) begin
        nxt_cnt = 4'h0;
        nxt_oe  = 1'b0;
        unique case (st_ff)
          BBC_I_DEVA: begin
            if (sh_ff[0]) begin
              nxt_st = BBC_I_RDAT;
              nxt_sh = rd_data;
              nxt_oe = ~rd_data[7];
            end else begin
              nxt_st = BBC_I_REGA;
            end
          end
          BBC_I_REGA: nxt_st = BBC_I_WDAT;
          BBC_I_WDAT: nxt_addr = addr + 8'h01;
          BBC_I_RDAT: begin
            nxt_sh = rd_data;
            nxt_oe = ~rd_data[7];
          end
          default: nxt_st = BBC_I_IDLE;
        endcase
      end else begin
        nxt_cnt = cnt_ff + 4'h1;
        if (st_ff == BBC_I_RDAT) begin
          nxt_sh = {sh_ff[6:0], 1'b0};
          nxt_oe = ~sh_ff[6];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s   <= 3'h7;
      sda_s   <= 3'h7;
      st_ff   <= BBC_I_IDLE;
      cnt_ff  <= 4'h0;
      sh_ff   <= 8'h00;
      addr    <= 8'h00;
      wr_data <= 8'h00;
      sda_oe  <= 1'b0;
      wr_stb  <= 1'b0;
    end else begin
      scl_s   <= {scl_s[1:0], scl_pin};
      sda_s   <= {sda_s[1:0], sda_pin};
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      sh_ff   <= nxt_sh;
      addr    <= nxt_addr;
      wr_data <= nxt_wd;
      sda_oe  <= nxt_oe;
      wr_stb  <= nxt_stb;
    end
  end
endmodule

// ==== hdl/bbc_pwm_meter.sv ====
/*
 * Duty meter: counts high samples in a window of 2**WIN_LOG2 ticks.
 * Assumes pwm_s is already synchronised and tick is a one-cycle pulse.
 */
`timescale 1ns/10ps
module bbc_pwm_meter import bbc_pkg::*; #(
  parameter int unsigned WIN = WIN_LOG2
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         en,
  input  wire logic         tick,
  input  wire logic         pwm_s,
  output logic      [WIN:0] duty
);
  logic [WIN-1:0] win_ff, nxt_win;
  logic [WIN:0]   hi_ff, nxt_hi, nxt_duty;

  always_comb begin
    nxt_win  = win_ff;
    nxt_hi   = hi_ff;
    nxt_duty = duty;
    if (!en) begin
      nxt_win  = '0;
      nxt_hi   = '0;
      nxt_duty = '0;
    end else if (tick) begin
      nxt_win = win_ff + 1'b1;
      nxt_hi  = hi_ff + {{WIN{1'b0}}, pwm_s};
      if (&win_ff) begin
        // Full window closes: publish, restart count
        nxt_duty = hi_ff + {{WIN{1'b0}}, pwm_s};
        nxt_hi   = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      win_ff <= '0;
      hi_ff  <= '0;
      duty   <= '0;
    end else begin
      win_ff <= nxt_win;
      hi_ff  <= nxt_hi;
      duty   <= nxt_duty;
    end
  end
endmodule

// ==== hdl/bbc_top.sv ====
/*
 * Brightness control of a two-string backlight: registers over the
 * serial bus, operating state, PWM duty scaling, ramper, sink controls.
 * Assumes MASTER_ENABLE_PIN, PWM_PIN, SCL and SDA are asynchronous pins;
 * the analog sinks take an 11-bit code plus a linear/exponential select.
 */
`timescale 1ns/10ps
// Contract
// - Each of the two current sinks has its own enable bit.
// - Reset: backlight off, sinks off, PWM off, linear, full code.
// - Master enable low holds registers at defaults and bus silent.
// - Master enable high, backlight bit clear: standby, registers kept, writable.
// - Zero code or no sink enabled keeps standby, boost and sinks off.
// - With PWM enabled, zero measured duty keeps standby.
// - Non-zero duty multiplies register code into an 11-bit value.
// - Both feedback-off bits set: boost off, sinks still on.
// - Mapping bit zero is exponential, one is linear.
// - Linear: current is offset plus step times code; zero gives none.
// - Exponential: base times ratio to the code; zero gives none.
// - Code is three low bits joined under eight high bits.
// - Code applied only on high byte write; host writes low first.
// - PWM disabled: pin ignored, register code ramped between set-points.
// - Ramp time setting spans zero to eight seconds.
// - Same ramp duration up or down, whatever the size of change.
// - PWM ramp bit zero scales after ramper, one ramps the product.
// - Master enable pin is active high.
module bbc_top import bbc_pkg::*; #(
  parameter logic [6:0]  DEV_ADDR = 7'h2A,  // Arbitrary value
  parameter int unsigned MS_CYCLES = MS_CYC,
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_DIV
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        MASTER_ENABLE_PIN,
  input  wire logic        PWM_PIN,
  input  wire logic        SCL,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE,
  output logic       [1:0] STATE,
  output logic             BOOST_EN,
  output logic       [1:0] SINK_EN,
  output logic      [10:0] BRIGHTNESS_CODE,
  output logic             MAP_LINEAR
);
  localparam int unsigned CW = 11;

  logic [1:0]    master_enable_pin_s, pwm_p;
  logic          master_enable_pin;
  logic [7:0]    ctrl_ff, nxt_ctrl, ramp_ff, nxt_ramp;
  logic [7:0]    lo_ff, nxt_lo, hi_ff, nxt_hi;
  logic [7:0]    ena_ff, nxt_ena, fbk_ff, nxt_fbk;
  logic [CW-1:0] code_ff, nxt_code;
  logic          wr_stb;
  logic [7:0]    bus_addr, wr_data;
  logic [7:0]    rd_data;
  logic          sda_oe;
  logic [7:0]    smp_ff, nxt_smp;
  logic          tick_ff, nxt_tick;
  logic [WIN_LOG2:0] duty;
  logic          pwm_en, pwm_ramp;

  // Ramper state
  logic [CW-1:0] tgt_ff, nxt_tgt, start_ff, nxt_start, cur_ff, nxt_cur;
  logic [RAMP_STEPS_LOG2:0] k_ff, nxt_k;
  logic [31:0]   stp_ff, nxt_stp, step_cyc;
  logic [CW-1:0] target, ramp_pos, sink_code;
  logic signed [CW+1:0] diff;
  logic signed [CW+RAMP_STEPS_LOG2+2:0] prod_diff;

  // Output registers
  bbc_state_t    st_ff, nxt_st;
  logic          boost_ff, nxt_boost;
  logic [1:0]    sink_ff, nxt_sink;
  logic [CW-1:0] out_ff, nxt_out;
  logic          lin_ff, nxt_lin;

  assign master_enable_pin     = master_enable_pin_s[1];
  assign pwm_en   = ctrl_ff[CTRL_PWM_EN];
  assign pwm_ramp = ctrl_ff[CTRL_PWM_RAMP];

  // Open drain: only ever pulls low
  assign SDA_O = 1'b0;
  assign SDA_OE = sda_oe;

  bbc_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_bus (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .en      (master_enable_pin),
    .scl_pin (SCL),
    .sda_pin (SDA_I),
    .rd_data (rd_data),
    .sda_oe  (sda_oe),
    .wr_stb  (wr_stb),
    .addr    (bus_addr),
    .wr_data (wr_data)
  );

  bbc_pwm_meter #(
    .WIN (WIN_LOG2)
  ) u_meter (
    .clk    (CLK),
    .arst_n (ARST_N),
    .en     (master_enable_pin & pwm_en),
    .tick   (tick_ff),
    .pwm_s  (pwm_p[1]),
    .duty   (duty)
  );

  // Duty times code, truncated; full window gives the code itself
  function automatic logic [CW-1:0] scale(input logic [CW-1:0] c,
                                          input logic [WIN_LOG2:0] d);
    logic [CW+WIN_LOG2:0] p;
    p = c * d;
    return p[CW+WIN_LOG2-1:WIN_LOG2];
  endfunction

  // Register file
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ramp = ramp_ff;
    nxt_lo   = lo_ff;
    nxt_hi   = hi_ff;
    nxt_ena  = ena_ff;
    nxt_fbk  = fbk_ff;
    nxt_code = code_ff;
    if (!master_enable_pin) begin
      nxt_ctrl = RST_CTRL;
      nxt_ramp = RST_RAMP;
      nxt_lo   = RST_BRT_LO;
      nxt_hi   = RST_BRT_HI;
      nxt_ena  = RST_ENABLE;
      nxt_fbk  = RST_FBK;
      nxt_code = {RST_BRT_HI, RST_BRT_LO[2:0]};
    end else if (wr_stb) begin
      // Writes accepted in standby as well as active
      unique case (bus_addr)
        OFF_CTRL:   nxt_ctrl = wr_data;
        OFF_RAMP:   nxt_ramp = wr_data;
        OFF_BRT_LO: nxt_lo = wr_data;
        OFF_BRT_HI: begin
          nxt_hi   = wr_data;
          nxt_code = {wr_data, lo_ff[2:0]};
        end
        OFF_ENABLE: nxt_ena = wr_data;
        OFF_FBK:    nxt_fbk = wr_data;
        default:    nxt_code = code_ff;
      endcase
    end
  end

  always_comb begin
    unique case (bus_addr)
      OFF_CTRL:   rd_data = ctrl_ff;
      OFF_RAMP:   rd_data = ramp_ff;
      OFF_BRT_LO: rd_data = lo_ff;
      OFF_BRT_HI: rd_data = hi_ff;
      OFF_ENABLE: rd_data = ena_ff;
      OFF_FBK:    rd_data = fbk_ff;
      default:    rd_data = 8'h00;
    endcase
  end

  // Sample tick divider
  always_comb begin
    nxt_smp  = smp_ff + 8'h01;
    nxt_tick = 1'b0;
    if (smp_ff >= 8'(SAMPLE_CYCLES - 1)) begin
      nxt_smp  = 8'h00;
      nxt_tick = 1'b1;
    end
  end

  // Ramper: 2**RAMP_STEPS_LOG2 equal steps, duration set by the step
  // interval alone, so the size of the change does not matter
  assign step_cyc = (ramp_ms(ramp_ff[RAMP_LSB+3:RAMP_LSB]) * MS_CYCLES)
                    >> RAMP_STEPS_LOG2;
  assign target = (pwm_en && pwm_ramp) ? scale(code_ff, duty)
                                       : code_ff;
  assign diff = $signed({2'b00, tgt_ff}) - $signed({2'b00, start_ff});
  assign prod_diff = diff * $signed({1'b0, k_ff});
  assign ramp_pos = CW'($signed({2'b00, start_ff})
                        + (prod_diff >>> RAMP_STEPS_LOG2));

  always_comb begin
    nxt_tgt   = tgt_ff;
    nxt_start = start_ff;
    nxt_cur   = cur_ff;
    nxt_k     = k_ff;
    nxt_stp   = stp_ff;
    if (!master_enable_pin) begin
      nxt_tgt   = '0;
      nxt_start = '0;
      nxt_cur   = '0;
      nxt_k     = '0;
      nxt_stp   = '0;
    end else if (target != tgt_ff) begin
      // New set-point restarts from where the output stands
      nxt_tgt   = target;
      nxt_start = cur_ff;
      nxt_k     = '0;
      nxt_stp   = '0;
    end else if (k_ff[RAMP_STEPS_LOG2] || step_cyc == 32'h0000_0000) begin
      nxt_cur = tgt_ff;
      nxt_k   = {1'b1, {RAMP_STEPS_LOG2{1'b0}}};
    end else if (stp_ff + 32'h0000_0001 >= step_cyc) begin
      nxt_stp = '0;
      nxt_k   = k_ff + 1'b1;
      nxt_cur = ramp_pos;
    end else begin
      nxt_stp = stp_ff + 32'h0000_0001;
    end
  end

  assign sink_code = (pwm_en && !pwm_ramp) ? scale(cur_ff, duty)
                                           : cur_ff;

  // Operating state and sink controls
  always_comb begin
    nxt_st    = BBC_STANDBY;
    nxt_boost = 1'b0;
    nxt_sink  = 2'b00;
    nxt_out   = '0;
    nxt_lin   = ctrl_ff[CTRL_LINEAR];
    if (!master_enable_pin) begin
      nxt_st = BBC_SHUTDOWN;
    end else if (!ena_ff[ENA_BL]) begin
      nxt_st = BBC_STANDBY;
    end else if (code_ff == '0 || ena_ff[1:0] == 2'b00) begin
      nxt_st = BBC_STANDBY;
    end else if (pwm_en && duty == '0) begin
      nxt_st = BBC_STANDBY;
    end else begin
      nxt_st    = BBC_ACTIVE;
      nxt_sink  = ena_ff[1:0];
      nxt_boost = fbk_ff[FBK_LSB+1:FBK_LSB] != FBK_BOOST_OFF;
      // Code zero means no sink current in either mapping
      nxt_out   = sink_code;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      master_enable_pin_s   <= 2'b00;
      pwm_p    <= 2'b00;
      ctrl_ff  <= RST_CTRL;
      ramp_ff  <= RST_RAMP;
      lo_ff    <= RST_BRT_LO;
      hi_ff    <= RST_BRT_HI;
      ena_ff   <= RST_ENABLE;
      fbk_ff   <= RST_FBK;
      code_ff  <= {RST_BRT_HI, RST_BRT_LO[2:0]};
      smp_ff   <= 8'h00;
      tick_ff  <= 1'b0;
      tgt_ff   <= '0;
      start_ff <= '0;
      cur_ff   <= '0;
      k_ff     <= '0;
      stp_ff   <= '0;
      st_ff    <= BBC_SHUTDOWN;
      boost_ff <= 1'b0;
      sink_ff  <= 2'b00;
      out_ff   <= '0;
      lin_ff   <= 1'b1;
    end else begin
      master_enable_pin_s   <= {master_enable_pin_s[0], MASTER_ENABLE_PIN};
      pwm_p    <= {pwm_p[0], PWM_PIN};
      ctrl_ff  <= nxt_ctrl;
      ramp_ff  <= nxt_ramp;
      lo_ff    <= nxt_lo;
      hi_ff    <= nxt_hi;
      ena_ff   <= nxt_ena;
      fbk_ff   <= nxt_fbk;
      code_ff  <= nxt_code;
      smp_ff   <= nxt_smp;
      tick_ff  <= nxt_tick;
      tgt_ff   <= nxt_tgt;
      start_ff <= nxt_start;
      cur_ff   <= nxt_cur;
      k_ff     <= nxt_k;
      stp_ff   <= nxt_stp;
      st_ff    <= nxt_st;
      boost_ff <= nxt_boost;
      sink_ff  <= nxt_sink;
      out_ff   <= nxt_out;
      lin_ff   <= nxt_lin;
    end
  end

  assign STATE           = st_ff;
  assign BOOST_EN        = boost_ff;
  assign SINK_EN         = sink_ff;
  assign BRIGHTNESS_CODE = out_ff;
  assign MAP_LINEAR      = lin_ff;
endmodule

// ==== testbench/bbc_top_monitor.sv ====
/*
 * Checker on the ports of bbc_top: operating state and sink outputs.
 * Assumes one clock domain and a bind from the bench top file.
 */
`timescale 1ns/10ps
module bbc_top_monitor import bbc_pkg::*; (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        MASTER_ENABLE_PIN,
  input wire logic        SCL,
  input wire logic        SDA_OE,
  input wire logic [1:0]  STATE,
  input wire logic        BOOST_EN,
  input wire logic [1:0]  SINK_EN,
  input wire logic [10:0] BRIGHTNESS_CODE,
  input wire logic        MAP_LINEAR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // Two synchroniser stages plus the state register
  sequence pin_low_run;
    !MASTER_ENABLE_PIN [*4];
  endsequence
  sequence pin_high_run;
    MASTER_ENABLE_PIN [*6];
  endsequence

  state_legal_a: assert property (STATE != 2'b11)
    else $error("state code undefined");
  idle_dark_a: assert property (STATE != BBC_ACTIVE |->
    SINK_EN == 2'h0 && !BOOST_EN && BRIGHTNESS_CODE == 11'h000)
    else $error("sink outputs lit outside active");
  active_lit_a: assert property (STATE == BBC_ACTIVE |-> SINK_EN != 2'h0)
    else $error("active with no sink enabled");
  boost_gate_a: assert property (BOOST_EN |-> STATE == BBC_ACTIVE)
    else $error("boost on outside active");
  shutdown_hold_a: assert property (pin_low_run |=>
    STATE == BBC_SHUTDOWN && !SDA_OE && MAP_LINEAR)
    else $error("not held in shutdown");
  wake_up_a: assert property (pin_high_run |-> STATE != BBC_SHUTDOWN)
    else $error("still shut down with enable high");
  down_cause_a: assert property (
    STATE == BBC_SHUTDOWN && $past(STATE) != BBC_SHUTDOWN |->
    !$past(MASTER_ENABLE_PIN, 2) || !$past(MASTER_ENABLE_PIN, 3))
    else $error("shutdown without enable low");
  ack_edge_a: assert property ($rose(SDA_OE) |-> !SCL)
    else $error("data line pulled while clock high");
endmodule

// ==== testbench/bbc_host_model.sv ====
/*
 * Host stand-in: serial bus master with a pull-up on SDA, and PWM source.
 * Assumes the bench calls wr and rd one at a time and sets pwm_high.
 */
`timescale 1ns/10ps
module bbc_host_model import bbc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda,
  output logic      pwm
);
  logic sda_low;
  int   pwm_high;
  int   pwm_cnt;

  // Released line reads high through the pull-up
  assign sda = !(sda_low || sda_oe);

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    pwm = 1'b0;
    pwm_high = 0;
    pwm_cnt = 0;
  end

  // Period 64 divides the 2048-sample window, so duty reads exact
  always @(posedge clk) begin
    #1;
    pwm_cnt = (pwm_cnt + 1) % 64;
    pwm = pwm_cnt < pwm_high;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    hold(4);
    scl = 1'b1;
    hold(4);
    s = sda;
    hold(4);
    scl = 1'b0;
    hold(4);
  endtask

  task automatic start();
    sda_low = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b0;
    hold(8);
  endtask

  // Ones release the line, so 8'hFF reads a byte and then sends no-ack
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({DEV_ADDR, 1'b0}, rx, a0);
    xfer(r, rx, a1);
    xfer(d, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic a;
    start();
    xfer({DEV_ADDR, 1'b0}, d, a);
    xfer(r, d, a);
    start();
    xfer({DEV_ADDR, 1'b1}, d, a);
    xfer(8'hFF, d, a);
    stop();
  endtask
endmodule

// ==== testbench/test_backlight_brightness_control.sv ====
/*
 * Self-checking bench of the backlight brightness control block.
 * Assumes the host model drives the serial bus and the PWM pin.
 */
`timescale 1ns/10ps
module test_backlight_brightness_control import bbc_pkg::*; ();
  logic        clk;
  logic        arst_n;
  logic        master_en;
  wire         scl;
  wire         sda;
  wire         pwm;
  logic        sda_o;
  logic        sda_oe;
  logic [1:0]  state;
  logic        boost_en;
  logic [1:0]  sink_en;
  logic [10:0] code;
  logic        map_linear;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // Short millisecond and sample-rate counts keep ramps and windows brief
  bbc_top #(.MS_CYCLES(256), .SAMPLE_CYCLES(1)) DUT (
    .CLK(clk), .ARST_N(arst_n), .MASTER_ENABLE_PIN(master_en), .PWM_PIN(pwm),
    .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .STATE(state),
    .BOOST_EN(boost_en), .SINK_EN(sink_en), .BRIGHTNESS_CODE(code),
    .MAP_LINEAR(map_linear));
  bbc_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda), .pwm(pwm));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic outs(input string what, input logic [1:0] st, input logic b,
                      input logic [1:0] s, input logic [10:0] c);
    check(what, {state, boost_en, sink_en, code}, {st, b, s, c});
  endtask

  task automatic put(input logic [7:0] r, input logic [7:0] d);
    logic ok;
    host.wr(r, d, ok);
    check("write ack", 16'(ok), 16'h0001);
    tick(8);
  endtask

  task automatic s_defaults();
    logic [7:0] offs [7] = '{OFF_CTRL, OFF_RAMP, OFF_BRT_LO, OFF_BRT_HI, OFF_ENABLE,
                             OFF_FBK, 8'h01};
    logic [7:0] rst [7] = '{8'h08, 8'h00, 8'h07, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      host.rd(offs[i], d);
      check("reset value", 16'(d), 16'(rst[i]));
    end
    check("linear after reset", 16'(map_linear), 16'h0001);
    check("data out low", 16'(sda_o), 16'h0000);
    outs("standby", BBC_STANDBY, 1'b0, 2'h0, 11'h000);
  endtask

  task automatic s_enable();
    put(OFF_ENABLE, 8'h10);
    outs("no sinks", BBC_STANDBY, 1'b0, 2'h0, 11'h000);
    put(OFF_ENABLE, 8'h11);
    outs("sink one", BBC_ACTIVE, 1'b1, 2'h1, 11'h7FF);
    put(OFF_ENABLE, 8'h12);
    outs("sink two", BBC_ACTIVE, 1'b1, 2'h2, 11'h7FF);
    put(OFF_ENABLE, 8'h13);
    outs("both sinks", BBC_ACTIVE, 1'b1, 2'h3, 11'h7FF);
  endtask

  task automatic s_code();
    put(OFF_BRT_LO, 8'h05);
    outs("low only", BBC_ACTIVE, 1'b1, 2'h3, 11'h7FF);
    put(OFF_BRT_HI, 8'h12);
    outs("joined", BBC_ACTIVE, 1'b1, 2'h3, 11'h095);
    put(OFF_BRT_LO, 8'h00);
    put(OFF_BRT_HI, 8'h00);
    outs("zero code", BBC_STANDBY, 1'b0, 2'h0, 11'h000);
    put(OFF_BRT_HI, 8'h40);
    outs("restored", BBC_ACTIVE, 1'b1, 2'h3, 11'h200);
  endtask

  task automatic s_map_fbk();
    put(OFF_CTRL, 8'h00);
    check("exponential", 16'(map_linear), 16'h0000);
    put(OFF_CTRL, 8'h08);
    check("linear", 16'(map_linear), 16'h0001);
    put(OFF_FBK, 8'h18);
    outs("boost off", BBC_ACTIVE, 1'b0, 2'h3, 11'h200);
    put(OFF_FBK, 8'h10);
    outs("boost back", BBC_ACTIVE, 1'b1, 2'h3, 11'h200);
  endtask

  task automatic s_pwm();
    host.pwm_high = 0;
    put(OFF_CTRL, 8'h09);
    tick(4200);
    outs("zero duty", BBC_STANDBY, 1'b0, 2'h0, 11'h000);
    host.pwm_high = 32;
    tick(4200);
    outs("half duty", BBC_ACTIVE, 1'b1, 2'h3, 11'h100);
    put(OFF_RAMP, 8'h08);
    put(OFF_CTRL, 8'h0B);
    check("product ramping", 16'(code != 11'h100), 16'h0001);
    tick(300);
    outs("ramped product", BBC_ACTIVE, 1'b1, 2'h3, 11'h100);
    put(OFF_RAMP, 8'h00);
    put(OFF_CTRL, 8'h08);
    host.pwm_high = 0;
    tick(4200);
    outs("pin ignored", BBC_ACTIVE, 1'b1, 2'h3, 11'h200);
  endtask

  task automatic ramp_to(input logic [7:0] hi, input logic [10:0] exp, output int t);
    logic [10:0] from;
    logic        mid;
    from = code;
    mid = 1'b0;
    t = 0;
    put(OFF_BRT_HI, hi);
    while (code !== exp && t < 1000) begin
      if (code !== from && code !== exp)
        mid = 1'b1;
      tick(1);
      t++;
    end
    check("ramp end", 16'(code), 16'(exp));
    check("ramp midway", 16'(mid), 16'h0001);
  endtask

  task automatic s_ramp();
    int t_up;
    int t_down;
    put(OFF_RAMP, 8'h08);
    ramp_to(8'h80, 11'h400, t_up);
    ramp_to(8'h10, 11'h080, t_down);
    check("ramp span", 16'(t_up > 150 && t_up < 300), 16'h0001);
    check("same span", 16'(t_up - t_down), 16'h0000);
    put(OFF_RAMP, 8'h00);
  endtask

  task automatic s_shutdown();
    logic       ok;
    logic [7:0] d;
    master_en = 1'b0;
    tick(6);
    outs("shutdown", BBC_SHUTDOWN, 1'b0, 2'h0, 11'h000);
    host.wr(OFF_BRT_HI, 8'h11, ok);
    check("bus silent", 16'(ok), 16'h0000);
    master_en = 1'b1;
    tick(10);
    host.rd(OFF_BRT_HI, d);
    check("defaults back", 16'(d), 16'h00FF);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    master_en = 1'b1;
    tick(20);
    arst_n = 1'b1;
    tick(10);
    s_defaults();
    s_enable();
    s_code();
    s_map_fbk();
    s_pwm();
    s_ramp();
    s_shutdown();
    results();
  end
endmodule

bind bbc_top bbc_top_monitor chk (
  .CLK(CLK), .ARST_N(ARST_N), .MASTER_ENABLE_PIN(MASTER_ENABLE_PIN), .SCL(SCL),
  .SDA_OE(SDA_OE), .STATE(STATE), .BOOST_EN(BOOST_EN), .SINK_EN(SINK_EN),
  .BRIGHTNESS_CODE(BRIGHTNESS_CODE), .MAP_LINEAR(MAP_LINEAR));
